/* File: usmf_top.sv */
/*
  Mode decode and channel status / interrupt mask logic of a multi-protocol
  serial controller, as an Avalon-MM slave. Assumes the serial datapath runs
  on CLK_SYS and reports its events as one-cycle pulses; modem pins are
  asynchronous and are synchronised here.
*/
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
module usmf_top (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  // Avalon-MM slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Modem pins, asynchronous
  input  wire logic        CTS,
  input  wire logic        DCD,
  input  wire logic        DSR,
  input  wire logic        RI,
  // Datapath events, one-cycle pulses
  input  wire logic        EV_PARITY,
  input  wire logic        EV_PARITY_ONE,
  input  wire logic        EV_FRAME,
  input  wire logic        EV_OVERRUN,
  input  wire logic        EV_BREAK,
  input  wire logic        EV_MANCH,
  input  wire logic        EV_LIN_BIT,
  input  wire logic        EV_LIN_SYNC,
  input  wire logic        EV_LIN_IDPAR,
  input  wire logic        EV_LIN_CSUM,
  input  wire logic        EV_LIN_NORESP,
  input  wire logic        EV_LIN_DONE,
  input  wire logic        EV_LIN_ID,
  input  wire logic        EV_NACK,
  input  wire logic        EV_MAX_REPEAT,
  input  wire logic        EV_UNDERRUN,
  input  wire logic        EV_IDLE_TIMEOUT,
  input  wire logic        EV_BREAK_TAKEN,
  // Datapath levels
  input  wire logic        DMA_RX_FULL,
  input  wire logic        RX_CHAR_AVAILABLE,
  input  wire logic        TX_HOLDING_EMPTY,
  input  wire logic        TX_SHIFT_EMPTY,
  // Decoded configuration
  output logic             SYNC_MODE,
  output logic             SPI_MODE,
  output logic             SPI_SLAVE,
  output logic             SPI_SHIFT_ON_LEAD,
  output logic             SPI_CAPTURE_ON_LEAD,
  output logic             SPI_IDLE_LEVEL,
  output logic      [3:0]  CHAR_BITS,
  output logic      [1:0]  CLOCK_SOURCE_SEL,
  output logic             CLOCK_SEL_RESERVED,
  output logic      [3:0]  MODE_CODE,
  output logic             MODE_RESERVED,
  output logic             LIN_SLAVE,
  output logic      [16:0] RX_IDLE_LIMIT,
  // Commands to datapath and interrupt
  output logic             TX_ENABLE,
  output logic             BREAK_BEGIN,
  output logic             IDLE_RESTART,
  output logic             IRQ
);
  logic [3:0]  pin_meta_reg;
  logic [3:0]  pin_sync_reg;
  logic [3:0]  pin_last_reg;
  logic [31:0] mode_reg;
  logic [31:0] mask_reg;
  logic [31:0] snap_reg;
  logic [31:0] sticky_reg;
  logic [31:0] sticky_next;
  logic [31:0] status;
  logic [31:0] wdata;
  logic [31:0] lanes;
  logic [31:0] set_w;
  logic        break_pend_reg;
  logic        accept;
  logic        wr_acc;
  logic        rd_acc;
  logic        stat_clr;
  logic        nack_clr;
  logic        idle_rst;
  logic        lin_slave_now;
  logic        spi_slave_now;
  logic        multidrop;

  function automatic logic [31:0] be_mask(input logic [31:0] d, input logic [3:0] be);
    be_mask = d & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] fold_alias(input logic [31:0] d);
    fold_alias = d;
    fold_alias[usmf_pkg::ST_MANCH]   = d[usmf_pkg::ST_MANCH] | d[usmf_pkg::MASK_ALIAS];
    fold_alias[usmf_pkg::MASK_ALIAS] = d[usmf_pkg::ST_MANCH] | d[usmf_pkg::MASK_ALIAS];
  endfunction

  // Request is taken at the edge where waitrequest is seen low
  assign accept   = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
  assign wr_acc   = accept & AVS_WRITE;
  assign rd_acc   = accept & AVS_READ;
  assign wdata    = be_mask(AVS_WRITEDATA, AVS_BYTEENABLE);
  assign lanes    = be_mask(32'hFFFFFFFF, AVS_BYTEENABLE);
  assign stat_clr = wr_acc && AVS_ADDRESS == usmf_pkg::OFS_COMMAND && wdata[usmf_pkg::CMD_STAT_CLEAR];
  assign nack_clr = wr_acc && AVS_ADDRESS == usmf_pkg::OFS_COMMAND && wdata[usmf_pkg::CMD_NACK_CLEAR];
  assign idle_rst = wr_acc && AVS_ADDRESS == usmf_pkg::OFS_COMMAND && wdata[usmf_pkg::CMD_IDLE_RSTRT];
  assign lin_slave_now = mode_reg[3:0] == usmf_pkg::MD_LIN_SLV;
  assign spi_slave_now = mode_reg[3:0] == usmf_pkg::MD_SPI_SLV;
  // Multidrop is parity code 11x, so only the upper two parity bits count
  assign multidrop     = mode_reg[usmf_pkg::PAR_LSB + 1 +: 2] == usmf_pkg::PAR_MULTIDROP[2:1];

  // Modem pins pass two flops before use
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
      pin_last_reg <= 4'h0;
    end else begin
      pin_meta_reg <= {CTS, DCD, DSR, RI};
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
    end
  end

  // Bus handshake: one wait cycle, read data loaded before the accepting edge
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= usmf_pkg::RESET_WORD;
      snap_reg        <= usmf_pkg::RESET_WORD;
    end else begin
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
      if (AVS_READ && AVS_WAITREQUEST) begin
        unique case (AVS_ADDRESS)
          usmf_pkg::OFS_MODE:       AVS_READDATA <= mode_reg;
          usmf_pkg::OFS_IRQ_STATE:  AVS_READDATA <= mask_reg;
          usmf_pkg::OFS_CONDITION:  AVS_READDATA <= status;
          usmf_pkg::OFS_IDLE_LIMIT: AVS_READDATA <= {15'h0000, RX_IDLE_LIMIT};
          default:                  AVS_READDATA <= usmf_pkg::RESET_WORD;
        endcase
        snap_reg <= (AVS_ADDRESS == usmf_pkg::OFS_CONDITION) ? status : usmf_pkg::RESET_WORD;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      mode_reg      <= usmf_pkg::RESET_WORD;
      RX_IDLE_LIMIT <= 17'h00000;
    end else if (wr_acc) begin
      if (AVS_ADDRESS == usmf_pkg::OFS_MODE)
        mode_reg <= wdata | (mode_reg & ~lanes);
      if (AVS_ADDRESS == usmf_pkg::OFS_IDLE_LIMIT)
        RX_IDLE_LIMIT <= wdata[16:0] | (RX_IDLE_LIMIT & ~lanes[16:0]);
    end
  end

  // Interrupt mask set and clear; unimplemented bits never stored
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      mask_reg <= usmf_pkg::RESET_WORD;
    end else if (wr_acc && AVS_ADDRESS == usmf_pkg::OFS_IRQ_SET) begin
      mask_reg <= mask_reg | (fold_alias(wdata) & usmf_pkg::MASK_IMPL);
    end else if (wr_acc && AVS_ADDRESS == usmf_pkg::OFS_IRQ_CLEAR) begin
      mask_reg <= mask_reg & ~(fold_alias(wdata) & usmf_pkg::MASK_IMPL);
    end
  end

  // Sticky flag sources
  always_comb begin
    set_w = 32'h00000000;
    set_w[usmf_pkg::ST_BREAK]     = EV_BREAK;
    set_w[usmf_pkg::ST_OVERRUN]   = EV_OVERRUN;
    set_w[usmf_pkg::ST_FRAME]     = EV_FRAME;
    set_w[usmf_pkg::ST_PARITY]    = EV_PARITY | (multidrop & EV_PARITY_ONE);
    set_w[usmf_pkg::ST_TIMEOUT]   = EV_IDLE_TIMEOUT;
    set_w[usmf_pkg::ST_REPEAT]    = spi_slave_now ? EV_UNDERRUN : EV_MAX_REPEAT;
    set_w[usmf_pkg::ST_NACK]      = EV_NACK;
    set_w[usmf_pkg::ST_LIN_ID]    = EV_LIN_ID;
    set_w[usmf_pkg::ST_LIN_DONE]  = EV_LIN_DONE;
    set_w[usmf_pkg::ST_CHG_LSB +: 4] = pin_sync_reg ^ pin_last_reg;
    set_w[usmf_pkg::ST_MANCH]     = EV_MANCH;
    set_w[usmf_pkg::ST_LIN_BIT]   = EV_LIN_BIT;
    set_w[usmf_pkg::ST_LIN_SYNC]  = EV_LIN_SYNC & lin_slave_now;
    set_w[usmf_pkg::ST_LIN_IDPAR] = EV_LIN_IDPAR;
    set_w[usmf_pkg::ST_LIN_CSUM]  = EV_LIN_CSUM;
    set_w[usmf_pkg::ST_LIN_NORSP] = EV_LIN_NORESP;
  end

  // Clears first, sets after, so an event in the clearing cycle survives
  always_comb begin
    sticky_next = sticky_reg;
    if (stat_clr) begin
      sticky_next[usmf_pkg::ST_LIN_NORSP:usmf_pkg::ST_MANCH] = 6'h00;
      sticky_next[usmf_pkg::ST_PARITY:usmf_pkg::ST_OVERRUN]  = 3'h0;
      sticky_next[usmf_pkg::ST_BREAK]    = 1'b0;
      sticky_next[usmf_pkg::ST_REPEAT]   = 1'b0;
      sticky_next[usmf_pkg::ST_LIN_ID]   = 1'b0;
      sticky_next[usmf_pkg::ST_LIN_DONE] = 1'b0;
    end
    if (nack_clr)
      sticky_next[usmf_pkg::ST_NACK] = 1'b0;
    if (idle_rst)
      sticky_next[usmf_pkg::ST_TIMEOUT] = 1'b0;
    // Only the change bits that software actually saw are dropped
    if (rd_acc)
      sticky_next[usmf_pkg::ST_CHG_LSB +: 4] = sticky_reg[usmf_pkg::ST_CHG_LSB +: 4]
                                               & ~snap_reg[usmf_pkg::ST_CHG_LSB +: 4];
    sticky_next = sticky_next | set_w;
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN)
      sticky_reg <= usmf_pkg::RESET_WORD;
    else
      sticky_reg <= sticky_next;
  end

  // Status word as software sees it
  always_comb begin
    status = sticky_reg;
    status[usmf_pkg::ST_TIMEOUT]     = sticky_reg[usmf_pkg::ST_TIMEOUT] & (RX_IDLE_LIMIT != 17'h00000);
    status[usmf_pkg::ST_PIN_LSB +: 4] = pin_sync_reg;
    status[usmf_pkg::ST_DMA_FULL]    = DMA_RX_FULL;
    status[usmf_pkg::ST_RX_AVAIL]    = RX_CHAR_AVAILABLE;
    status[usmf_pkg::ST_TX_DRAIN]    = TX_ENABLE & TX_HOLDING_EMPTY & TX_SHIFT_EMPTY;
    status[usmf_pkg::ST_TX_FREE]     = TX_ENABLE & TX_HOLDING_EMPTY & ~break_pend_reg;
    status = status & ~32'hC0000818;
  end

  // Transmitter enable and pending break request
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      TX_ENABLE      <= 1'b0;
      break_pend_reg <= 1'b0;
      BREAK_BEGIN    <= 1'b0;
      IDLE_RESTART   <= 1'b0;
    end else begin
      BREAK_BEGIN  <= wr_acc && AVS_ADDRESS == usmf_pkg::OFS_COMMAND
                      && wdata[usmf_pkg::CMD_BRK_BEGIN];
      IDLE_RESTART <= idle_rst;
      if (wr_acc && AVS_ADDRESS == usmf_pkg::OFS_COMMAND && wdata[usmf_pkg::CMD_TX_DISABLE])
        TX_ENABLE <= 1'b0;
      else if (wr_acc && AVS_ADDRESS == usmf_pkg::OFS_COMMAND && wdata[usmf_pkg::CMD_TX_ENABLE])
        TX_ENABLE <= 1'b1;
      if (wr_acc && AVS_ADDRESS == usmf_pkg::OFS_COMMAND && wdata[usmf_pkg::CMD_BRK_BEGIN])
        break_pend_reg <= 1'b1;
      else if (EV_BREAK_TAKEN)
        break_pend_reg <= 1'b0;
    end
  end

  // Mode decode, registered so every output is a flop
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      SYNC_MODE           <= 1'b0;
      SPI_MODE            <= 1'b0;
      SPI_SLAVE           <= 1'b0;
      SPI_SHIFT_ON_LEAD   <= 1'b0;
      SPI_CAPTURE_ON_LEAD <= 1'b0;
      SPI_IDLE_LEVEL      <= 1'b0;
      CHAR_BITS           <= 4'h5;
      CLOCK_SOURCE_SEL    <= usmf_pkg::CK_PERIPH;
      CLOCK_SEL_RESERVED  <= 1'b0;
      MODE_CODE           <= usmf_pkg::MD_NORMAL;
      MODE_RESERVED       <= 1'b0;
      LIN_SLAVE           <= 1'b0;
      IRQ                 <= 1'b0;
    end else begin
      SPI_MODE  <= mode_reg[3:1] == usmf_pkg::MD_SPI_MST[3:1];
      SPI_SLAVE <= spi_slave_now;
      SYNC_MODE <= mode_reg[3:1] != usmf_pkg::MD_SPI_MST[3:1] && mode_reg[usmf_pkg::SYNC_BIT];
      SPI_SHIFT_ON_LEAD   <= mode_reg[3:1] == usmf_pkg::MD_SPI_MST[3:1] && !mode_reg[usmf_pkg::SYNC_BIT];
      SPI_CAPTURE_ON_LEAD <= mode_reg[3:1] == usmf_pkg::MD_SPI_MST[3:1] && mode_reg[usmf_pkg::SYNC_BIT];
      SPI_IDLE_LEVEL      <= mode_reg[usmf_pkg::IDLE_BIT];
      CHAR_BITS           <= 4'h5 + {2'h0, mode_reg[usmf_pkg::CHAR_LENGTH_SEL_LSB +: 2]};
      // Reserved clock code falls back to the peripheral clock
      CLOCK_SOURCE_SEL    <= (mode_reg[usmf_pkg::CLKS_LSB +: 2] == usmf_pkg::CK_RSVD)
                             ? usmf_pkg::CK_PERIPH : mode_reg[usmf_pkg::CLKS_LSB +: 2];
      CLOCK_SEL_RESERVED  <= mode_reg[usmf_pkg::CLKS_LSB +: 2] == usmf_pkg::CK_RSVD;
      MODE_CODE           <= mode_reg[3:0];
      LIN_SLAVE           <= lin_slave_now;
      unique case (mode_reg[3:0])
        usmf_pkg::MD_NORMAL, usmf_pkg::MD_RS485, usmf_pkg::MD_HANDSHAKE, usmf_pkg::MD_MODEM,
        usmf_pkg::MD_ISO_T0, usmf_pkg::MD_ISO_T1, usmf_pkg::MD_IRDA, usmf_pkg::MD_LIN_MST,
        usmf_pkg::MD_LIN_SLV, usmf_pkg::MD_SPI_MST, usmf_pkg::MD_SPI_SLV: MODE_RESERVED <= 1'b0;
        default: MODE_RESERVED <= 1'b1;
      endcase
      IRQ <= |(status & mask_reg & usmf_pkg::IRQ_SOURCE);
    end
  end

  // Checks
  sequence s_write_to(logic [7:0] ofs);
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == ofs;
  endsequence

  sequence s_read_status;
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == usmf_pkg::OFS_CONDITION;
  endsequence

  a_mask_set: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    s_write_to(usmf_pkg::OFS_IRQ_SET) |=> ((mask_reg & $past(wdata) & usmf_pkg::MASK_IMPL)
      == ($past(wdata) & usmf_pkg::MASK_IMPL))) else $error("mask bit not set");
  a_mask_clear: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    s_write_to(usmf_pkg::OFS_IRQ_CLEAR) |=> (mask_reg & $past(wdata)) == 32'h00000000)
    else $error("mask bit not cleared");
  a_alias_mirror: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    mask_reg[usmf_pkg::ST_MANCH] == mask_reg[usmf_pkg::MASK_ALIAS]) else $error("alias differs");
  a_sync_slave_only: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    $rose(sticky_reg[usmf_pkg::ST_LIN_SYNC]) |-> $past(lin_slave_now)) else $error("sync flag not slave");
  a_change_flag: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (pin_sync_reg != pin_last_reg) |=> (sticky_reg[19:16] & $past(pin_sync_reg ^ pin_last_reg))
      == $past(pin_sync_reg ^ pin_last_reg)) else $error("change not flagged");
  a_read_clears: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    s_read_status ##0 (pin_sync_reg == pin_last_reg) |=> (sticky_reg[19:16] & $past(snap_reg[19:16])) == 4'h0)
    else $error("read did not clear");
  a_nack_hold: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    sticky_reg[usmf_pkg::ST_NACK] && !nack_clr |=> sticky_reg[usmf_pkg::ST_NACK]) else $error("nack dropped");
  a_timeout_zero: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    RX_IDLE_LIMIT == 17'h00000 |-> !status[usmf_pkg::ST_TIMEOUT]) else $error("timeout with zero limit");
  a_drain_off: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !TX_ENABLE |-> !status[usmf_pkg::ST_TX_DRAIN] && !status[usmf_pkg::ST_TX_FREE]) else $error("tx flag while off");
  a_irq_follow: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    |(status & mask_reg & usmf_pkg::IRQ_SOURCE) |=> IRQ) else $error("irq missing");
  a_char_len: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ##1 CHAR_BITS == 4'h5 + {2'h0, $past(mode_reg[7:6])}) else $error("length wrong");
endmodule

/* File: usmf_pkg.sv */
/*
  Package for the serial controller mode decode and status flag block:
  register offsets, field positions, reset values and mode encodings.
  Assumes a 32-bit Avalon-MM register port with byte addresses.
*/
package usmf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_COMMAND    = 8'h00;
  localparam logic [7:0] OFS_MODE       = 8'h04;
  localparam logic [7:0] OFS_IRQ_SET    = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATE  = 8'h10;
  localparam logic [7:0] OFS_CONDITION  = 8'h14;
  localparam logic [7:0] OFS_IDLE_LIMIT = 8'h24;

  // Command register bits
  localparam int CMD_TX_ENABLE  = 6;
  localparam int CMD_TX_DISABLE = 7;
  localparam int CMD_STAT_CLEAR = 8;
  localparam int CMD_BRK_BEGIN  = 9;
  localparam int CMD_IDLE_RSTRT = 11;
  localparam int CMD_NACK_CLEAR = 14;

  // Mode register fields
  localparam int MODE_LSB  = 0;
  localparam int CLKS_LSB  = 4;
  localparam int CHAR_LENGTH_SEL_LSB  = 6;
  localparam int SYNC_BIT  = 8;
  localparam int PAR_LSB   = 9;
  localparam int IDLE_BIT  = 16;
  localparam logic [2:0] PAR_MULTIDROP = 3'h6;

  // Mode field encodings
  localparam logic [3:0] MD_NORMAL    = 4'h0;
  localparam logic [3:0] MD_RS485     = 4'h1;
  localparam logic [3:0] MD_HANDSHAKE = 4'h2;
  localparam logic [3:0] MD_MODEM     = 4'h3;
  localparam logic [3:0] MD_ISO_T0    = 4'h4;
  localparam logic [3:0] MD_ISO_T1    = 4'h6;
  localparam logic [3:0] MD_IRDA      = 4'h8;
  localparam logic [3:0] MD_LIN_MST   = 4'hA;
  localparam logic [3:0] MD_LIN_SLV   = 4'hB;
  localparam logic [3:0] MD_SPI_MST   = 4'hE;
  localparam logic [3:0] MD_SPI_SLV   = 4'hF;

  // Clock source encodings
  localparam logic [1:0] CK_PERIPH = 2'h0;
  localparam logic [1:0] CK_DIV    = 2'h1;
  localparam logic [1:0] CK_RSVD   = 2'h2;
  localparam logic [1:0] CK_EXT    = 2'h3;

  // Status bit positions
  localparam int ST_RX_AVAIL  = 0;
  localparam int ST_TX_FREE   = 1;
  localparam int ST_BREAK     = 2;
  localparam int ST_OVERRUN   = 5;
  localparam int ST_FRAME     = 6;
  localparam int ST_PARITY    = 7;
  localparam int ST_TIMEOUT   = 8;
  localparam int ST_TX_DRAIN  = 9;
  localparam int ST_REPEAT    = 10;
  localparam int ST_DMA_FULL  = 12;
  localparam int ST_NACK      = 13;
  localparam int ST_LIN_ID    = 14;
  localparam int ST_LIN_DONE  = 15;
  localparam int ST_CHG_LSB   = 16;
  localparam int ST_PIN_LSB   = 20;
  localparam int ST_MANCH     = 24;
  localparam int ST_LIN_BIT   = 25;
  localparam int ST_LIN_SYNC  = 26;
  localparam int ST_LIN_IDPAR = 27;
  localparam int ST_LIN_CSUM  = 28;
  localparam int ST_LIN_NORSP = 29;
  localparam int MASK_ALIAS   = 20;

  // Implemented enable bits, and the status bits that may raise the interrupt
  localparam logic [31:0] MASK_IMPL  = 32'h3F1FF7E7;
  localparam logic [31:0] IRQ_SOURCE = 32'h3F0FF7E7;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam int IDLE_W = 17;
endpackage

/* File: usmf_peer.sv */
/* Far side of the block: datapath event pulses, level flags and modem pins.
   Assumes it shares CLK_SYS and that the bench sets lv and pin on a rising edge. */
`timescale 1ns/1ps
module usmf_peer (
  // Clock
  input  wire logic        clk,
  // Far side lines
  output logic      [17:0] ev,
  output logic      [3:0]  lv,
  output logic      [3:0]  pin
);
  initial begin
    ev  = 18'h00000;
    lv  = 4'h0;
    pin = 4'h0;
  end
  // Events last one cycle, as the datapath reports them
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
endmodule

/* File: usmf_top_tb.sv */
/* Self-checking bench for the mode decode and status block.
   Assumes usmf_pkg and usmf_peer are compiled first. */
`timescale 1ns/1ps
module usmf_top_tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [31:0] rdata, q;
  logic        wq, irq, spi, slv, shl, cpl, cres, mres, lslv, syncm, txe, brk_p, idl_p, idl_lvl;
  logic [3:0]  chr, lv, pin, mcode;
  logic [16:0] lim;
  int          n_brk = 0;
  int          n_idle = 0;
  logic [1:0]  clks;
  logic [17:0] ev;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  // Mode words and expected {spi,slave,phase/sync,bits,clock,clk rsvd,mode rsvd,lin slave}
  logic [8:0]  mw [12] = '{9'h000, 9'h151, 9'h0A2, 9'h0F3, 9'h004, 9'h006, 9'h008, 9'h00A, 9'h00B,
                           9'h00E, 9'h10F, 9'h005};
  logic [12:0] mx [12] = '{13'h00A0, 13'h04C8, 13'h00E4, 13'h0118, 13'h00A0, 13'h00A0, 13'h00A0,
                           13'h00A0, 13'h00A1, 13'h14A0, 13'h1AA0, 13'h00A2};
  always #50 clk = ~clk;
  usmf_top dut_u (.CLK_SYS(clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq),
    .CTS(pin[3]), .DCD(pin[2]), .DSR(pin[1]), .RI(pin[0]), .EV_PARITY(ev[0]), .EV_PARITY_ONE(ev[1]),
    .EV_FRAME(ev[2]), .EV_OVERRUN(ev[3]), .EV_BREAK(ev[4]), .EV_MANCH(ev[5]), .EV_LIN_BIT(ev[6]),
    .EV_LIN_SYNC(ev[7]), .EV_LIN_IDPAR(ev[8]), .EV_LIN_CSUM(ev[9]), .EV_LIN_NORESP(ev[10]),
    .EV_LIN_DONE(ev[11]), .EV_LIN_ID(ev[12]), .EV_NACK(ev[13]), .EV_MAX_REPEAT(ev[14]),
    .EV_UNDERRUN(ev[15]), .EV_IDLE_TIMEOUT(ev[16]), .EV_BREAK_TAKEN(ev[17]), .DMA_RX_FULL(lv[3]),
    .RX_CHAR_AVAILABLE(lv[2]), .TX_HOLDING_EMPTY(lv[1]), .TX_SHIFT_EMPTY(lv[0]), .SYNC_MODE(syncm),
    .SPI_MODE(spi), .SPI_SLAVE(slv), .SPI_SHIFT_ON_LEAD(shl), .SPI_CAPTURE_ON_LEAD(cpl),
    .SPI_IDLE_LEVEL(idl_lvl), .CHAR_BITS(chr), .CLOCK_SOURCE_SEL(clks), .CLOCK_SEL_RESERVED(cres),
    .MODE_CODE(mcode), .MODE_RESERVED(mres), .LIN_SLAVE(lslv), .RX_IDLE_LIMIT(lim), .TX_ENABLE(txe),
    .BREAK_BEGIN(brk_p), .IDLE_RESTART(idl_p), .IRQ(irq));
  usmf_peer peer_u (.clk(clk), .ev(ev), .lv(lv), .pin(pin));
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic [7:0] a, input logic r, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= r;
    wr <= !r;
    wd <= d;
    do @(posedge clk); while (wq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(a, 1'b1, 32'h00000000);
    chk(n, e, q);
  endtask
  always @(posedge clk) begin
    cyc++;
    // Command pulses stand one cycle, so each is counted once
    if (brk_p === 1'b1) n_brk++;
    if (idl_p === 1'b1) n_idle++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rchk(usmf_pkg::OFS_IRQ_STATE, usmf_pkg::RESET_WORD, "irq_enable_state");
    rchk(8'h3C, 32'h00000000, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      bus(usmf_pkg::OFS_MODE, 1'b0, {23'h000000, mw[i]});
      repeat (3) @(posedge clk);
      chk("decode", {19'h00000, mx[i]}, {19'h00000, spi, slv, spi ? {shl, cpl} : {syncm, 1'b0}, chr, clks,
          cres, mres, lslv});
    end
    $display("test decode done");
    bus(usmf_pkg::OFS_IRQ_SET, 1'b0, 32'hFFFFFFFF);
    rchk(usmf_pkg::OFS_IRQ_STATE, usmf_pkg::MASK_IMPL, "mask all");
    bus(usmf_pkg::OFS_IRQ_CLEAR, 1'b0, 32'h01000000);
    rchk(usmf_pkg::OFS_IRQ_STATE, usmf_pkg::MASK_IMPL & ~32'h01100000, "mask alias");
    bus(usmf_pkg::OFS_IRQ_CLEAR, 1'b0, 32'h00000000);
    rchk(usmf_pkg::OFS_IRQ_STATE, usmf_pkg::MASK_IMPL & ~32'h01100000, "mask zero");
    bus(usmf_pkg::OFS_IRQ_CLEAR, 1'b0, 32'hFFFFFFFF);
    bus(usmf_pkg::OFS_IRQ_SET, 1'b0, 32'h00100000);
    rchk(usmf_pkg::OFS_IRQ_STATE, 32'h01100000, "mask mirror");
    $display("test mask done");
    peer_u.pulse(5);
    peer_u.pulse(2);
    peer_u.pulse(13);
    peer_u.pulse(7);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    rchk(usmf_pkg::OFS_CONDITION, 32'h01002040, "sticky");
    bus(usmf_pkg::OFS_COMMAND, 1'b0, 32'h00000100);
    rchk(usmf_pkg::OFS_CONDITION, 32'h00002000, "status clear");
    chk("irq", 32'h0, {31'h0, irq});
    bus(usmf_pkg::OFS_COMMAND, 1'b0, 32'h00004000);
    rchk(usmf_pkg::OFS_CONDITION, 32'h00000000, "nack clear");
    $display("test flags done");
    peer_u.pin <= 4'hF;
    repeat (5) @(posedge clk);
    rchk(usmf_pkg::OFS_CONDITION, 32'h00FF0000, "pin change");
    rchk(usmf_pkg::OFS_CONDITION, 32'h00F00000, "read clear");
    $display("test modem done");
    peer_u.lv <= 4'hF;
    bus(usmf_pkg::OFS_COMMAND, 1'b0, 32'h00000040);
    rchk(usmf_pkg::OFS_CONDITION, 32'h00F01203, "tx on");
    peer_u.lv <= 4'hD;
    rchk(usmf_pkg::OFS_CONDITION, 32'h00F01001, "holding busy");
    peer_u.lv <= 4'hF;
    bus(usmf_pkg::OFS_COMMAND, 1'b0, 32'h00000080);
    rchk(usmf_pkg::OFS_CONDITION, 32'h00F01001, "tx off");
    $display("test levels done");
    bus(usmf_pkg::OFS_MODE, 1'b0, 32'h00010C0B);
    bus(usmf_pkg::OFS_IDLE_LIMIT, 1'b0, 32'h00000005);
    chk("mode code", 32'h0000000B, {28'h0000000, mcode});
    chk("idle level", 32'h00000001, {31'h00000000, idl_lvl});
    rchk(usmf_pkg::OFS_IDLE_LIMIT, 32'h00000005, "idle limit");
    chk("limit out", 32'h00000005, {15'h0000, lim});
    // Every event from parity-one to idle timeout except frame, nack and underrun, as LIN slave in multidrop
    for (int i = 1; i < 17; i++) begin
      if (i != 2 && i != 13 && i != 15)
        peer_u.pulse(i);
    end
    repeat (2) @(posedge clk);
    chk("irq", 32'h00000001, {31'h00000000, irq});
    rchk(usmf_pkg::OFS_CONDITION, 32'h3FF0D5A5, "all flags");
    bus(usmf_pkg::OFS_COMMAND, 1'b0, 32'h00000100);
    rchk(usmf_pkg::OFS_CONDITION, 32'h00F01101, "clear keeps timeout");
    chk("irq", 32'h00000000, {31'h00000000, irq});
    bus(usmf_pkg::OFS_IDLE_LIMIT, 1'b0, 32'h00000000);
    rchk(usmf_pkg::OFS_CONDITION, 32'h00F01001, "zero limit");
    bus(usmf_pkg::OFS_IDLE_LIMIT, 1'b0, 32'h00000005);
    bus(usmf_pkg::OFS_COMMAND, 1'b0, 32'h00000800);
    rchk(usmf_pkg::OFS_CONDITION, 32'h00F01001, "idle restart");
    chk("restart pulses", 32'h00000001, n_idle);
    bus(usmf_pkg::OFS_COMMAND, 1'b0, 32'h00000040);
    bus(usmf_pkg::OFS_COMMAND, 1'b0, 32'h00000200);
    chk("tx enable", 32'h00000001, {31'h00000000, txe});
    rchk(usmf_pkg::OFS_CONDITION, 32'h00F01201, "break pending");
    peer_u.pulse(17);
    rchk(usmf_pkg::OFS_CONDITION, 32'h00F01203, "break taken");
    chk("break pulses", 32'h00000001, n_brk);
    bus(usmf_pkg::OFS_MODE, 1'b0, 32'h0000000F);
    peer_u.pulse(14);
    rchk(usmf_pkg::OFS_CONDITION, 32'h00F01203, "repeat ignored");
    peer_u.pulse(15);
    rchk(usmf_pkg::OFS_CONDITION, 32'h00F01603, "underrun");
    $display("test more flags done");
    test_done();
  end
endmodule
